// >>> logic/pced_params.svh
/*
 * Offsets, field positions and reset values of the pin change edge detector.
 * Assumes inclusion by bare name from the package and the pced_top module.
 */
`ifndef PCED_PARAMS_SVH
`define PCED_PARAMS_SVH

`define PCED_OFS_RISE_EN      4'h0
`define PCED_OFS_FALL_EN      4'h1
`define PCED_OFS_FLAG         4'h2
`define PCED_OFS_IRQ_CTRL     4'h3
`define PCED_OFS_IRQ_STAT     4'h4
`define PCED_OFS_IRQ_MASK     4'h5
`define PCED_ADR_LSB          2
`define PCED_ADR_MSB          5
`define PCED_IMPL_BITS        6
`define PCED_REG_BITS         8
`define PCED_RST_EN           6'h00
`define PCED_RST_FLAG         6'h00
`define PCED_RST_CTRL         1'b0
`define PCED_CTRL_IRQ_EN_BIT  0
`define PCED_CTRL_SUMMARY_BIT 1
`define PCED_EV_RISE_BIT      0
`define PCED_EV_FALL_BIT      1
`define PCED_EV_BITS          2
`define PCED_RST_EV           2'h0

`endif

// >>> logic/pced_pkg.sv
/*
 * Types shared by the edge detector modules.
 * Assumes the parameter header is on the include path.
 */
package pced_pkg;
    `include "pced_params.svh"

    typedef enum logic [1:0] {
        PCED_BUS_IDLE = 2'b01,
        PCED_BUS_ACK  = 2'b10
    } pced_bus_state_t;

    typedef logic [`PCED_IMPL_BITS-1:0] pced_pins_t;
endpackage

// >>> logic/pced_edge_if.sv
/*
 * Carries synchronised pin edges from the detector to the register file.
 * Assumes both ends run on clk_sys.
 */
interface pced_edge_if #(
    parameter int NPINS = 6
);
    logic [NPINS-1:0] rise_hit;
    logic [NPINS-1:0] fall_hit;

    modport src (output rise_hit, output fall_hit);
    modport dst (input rise_hit, input fall_hit);
endinterface

// >>> logic/pced_sync_edge.sv
/*
 * Two flip-flop synchroniser and edge finder for each pin.
 * Assumes pins are asynchronous to clk_sys.
 */
module pced_sync_edge
    import pced_pkg::*;
#(
    parameter int NPINS = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [NPINS-1:0] pin_in,
    pced_edge_if.src              edges
);
    logic [NPINS-1:0] meta_r;
    logic [NPINS-1:0] sync_r;
    logic [NPINS-1:0] prev_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prev_r <= '0;
        end else begin
            prev_r <= sync_r;
        end
    end

    assign edges.rise_hit = sync_r & ~prev_r;
    assign edges.fall_hit = ~sync_r & prev_r;
endmodule

// >>> logic/pced_top.sv
/*
 * Pin change edge detector with Wishbone classic register slave.
 * Assumes a synchronous Wishbone master on clk_sys and asynchronous pins.
 */
`include "pced_params.svh"

module pced_top
    import pced_pkg::*;
#(
    parameter int NPINS = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [NPINS-1:0] pin_in,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [31:0]      adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    output logic                  irq_o
);
    // Refuse any pin count other than the six implemented bits
    if (NPINS != `PCED_IMPL_BITS) begin : g_npins_chk
        $error("NPINS must equal the implemented pin count");
    end

    pced_edge_if #(.NPINS(NPINS)) edges ();

    pced_sync_edge #(.NPINS(NPINS)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin_in  (pin_in),
        .edges   (edges)
    );

    pced_bus_state_t         bus_r;
    logic [NPINS-1:0]        rise_en_r;
    logic [NPINS-1:0]        fall_en_r;
    logic [NPINS-1:0]        flag_r;
    logic [NPINS-1:0]        flag_nxt;
    logic [NPINS-1:0]        new_hit;
    logic                    irq_en_r;
    logic [`PCED_EV_BITS-1:0] ev_stat_r;
    logic [`PCED_EV_BITS-1:0] ev_mask_r;
    logic                    summary;
    logic                    wr_stb;
    logic                    rd_stb;
    logic [3:0]              reg_idx;
    logic [31:0]             rd_data;

    function automatic logic hit(input logic [3:0] idx, input logic [3:0] ofs);
        hit = (idx == ofs);
    endfunction

    assign reg_idx = adr_i[`PCED_ADR_MSB:`PCED_ADR_LSB];
    assign wr_stb  = cyc_i && stb_i && we_i && (bus_r == PCED_BUS_IDLE) && sel_i[0];
    assign rd_stb  = cyc_i && stb_i && (bus_r == PCED_BUS_IDLE);

    // One wait state, ack dropped after one cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_r <= PCED_BUS_IDLE;
        end else begin
            unique case (bus_r)
                PCED_BUS_IDLE: begin
                    if (cyc_i && stb_i) begin
                        bus_r <= PCED_BUS_ACK;
                    end
                end
                PCED_BUS_ACK: begin
                    bus_r <= PCED_BUS_IDLE;
                end
            endcase
        end
    end

    assign ack_o = (bus_r == PCED_BUS_ACK);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rise_en_r <= `PCED_RST_EN;
            fall_en_r <= `PCED_RST_EN;
        end else if (wr_stb) begin
            if (hit(reg_idx, `PCED_OFS_RISE_EN)) begin
                rise_en_r <= dat_i[NPINS-1:0];
            end
            if (hit(reg_idx, `PCED_OFS_FALL_EN)) begin
                fall_en_r <= dat_i[NPINS-1:0];
            end
        end
    end

    assign new_hit = (edges.rise_hit & rise_en_r) | (edges.fall_hit & fall_en_r);

    always_comb begin
        flag_nxt = flag_r;
        if (wr_stb && hit(reg_idx, `PCED_OFS_FLAG)) begin
            flag_nxt = dat_i[NPINS-1:0];
        end
        flag_nxt = flag_nxt | new_hit;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flag_r <= `PCED_RST_FLAG;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_en_r <= `PCED_RST_CTRL;
        end else if (wr_stb && hit(reg_idx, `PCED_OFS_IRQ_CTRL)) begin
            irq_en_r <= dat_i[`PCED_CTRL_IRQ_EN_BIT];
        end
    end

    assign summary = |flag_r;

    // Sticky events, write one clears, new event wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ev_stat_r <= `PCED_RST_EV;
        end else begin
            for (int i = 0; i < `PCED_EV_BITS; i++) begin
                if (wr_stb && hit(reg_idx, `PCED_OFS_IRQ_STAT) && dat_i[i]) begin
                    ev_stat_r[i] <= 1'b0;
                end
            end
            if (|(edges.rise_hit & rise_en_r)) begin
                ev_stat_r[`PCED_EV_RISE_BIT] <= 1'b1;
            end
            if (|(edges.fall_hit & fall_en_r)) begin
                ev_stat_r[`PCED_EV_FALL_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ev_mask_r <= `PCED_RST_EV;
        end else if (wr_stb && hit(reg_idx, `PCED_OFS_IRQ_MASK)) begin
            ev_mask_r <= dat_i[`PCED_EV_BITS-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (irq_en_r && summary) || (|(ev_stat_r & ev_mask_r));
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (reg_idx)
            `PCED_OFS_RISE_EN:  rd_data[NPINS-1:0] = rise_en_r;
            `PCED_OFS_FALL_EN:  rd_data[NPINS-1:0] = fall_en_r;
            `PCED_OFS_FLAG:     rd_data[NPINS-1:0] = flag_r;
            `PCED_OFS_IRQ_CTRL: begin
                rd_data[`PCED_CTRL_IRQ_EN_BIT]  = irq_en_r;
                rd_data[`PCED_CTRL_SUMMARY_BIT] = summary;
            end
            `PCED_OFS_IRQ_STAT: rd_data[`PCED_EV_BITS-1:0] = ev_stat_r;
            `PCED_OFS_IRQ_MASK: rd_data[`PCED_EV_BITS-1:0] = ev_mask_r;
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            dat_o <= we_i ? 32'h0000_0000 : rd_data;
        end
    end
endmodule

// >>> tb/pced_properties.sv
/* Checker for pced_top port timing.
   Assumes bind onto pced_top, one clock. */
module pced_properties #(
    parameter int NPINS = 6
) (
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [31:0]      adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic             irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] sh_r [0:5];
    wire wr_t = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    wire rd_t = cyc_i && stb_i && !we_i && !ack_o;
    // Shadow of writable fields
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sh_r <= '{default: 6'h0};
        end else if (wr_t && adr_i[5:2] < 4'h6) begin
            sh_r[adr_i[5:2]] <= dat_i[5:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_taken; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_taken: assert property (p_ack_taken) else $error("no ack");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_upper; ack_o && $past(rd_t) |-> dat_o[31:6] == 26'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_unmap; ack_o && $past(rd_t && adr_i[5:2] > 4'h5) |-> dat_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_en_rb;
        ack_o && $past(rd_t && adr_i[5:2] < 4'h2) |-> dat_o[5:0] == sh_r[$past(adr_i[5:2])];
    endproperty
    a_en_rb: assert property (p_en_rb) else $error("enable readback");
    property p_ctl_rb; ack_o && $past(rd_t && adr_i[5:2] == 4'h3) |-> dat_o[0] == sh_r[3][0];
    endproperty
    a_ctl_rb: assert property (p_ctl_rb) else $error("irq enable readback");
    property p_irq_off; $past(!sh_r[3][0] && sh_r[5][1:0] == 2'h0) |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while gated");
    c_rd: cover property (ack_o && !we_i);
    c_wr: cover property (ack_o && we_i);
    c_irq: cover property ($rose(irq_o));
endmodule

bind pced_top pced_properties #(.NPINS(NPINS)) prop_u (.clk_sys(clk_sys), .reset(reset),
    .pin_in(pin_in), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

// >>> tb/pced_pin_model.sv
/* Six external port pins.
   Assumes the bench sets the target levels. */
module pced_pin_model (
    input  wire logic [5:0] level_tgt,
    input  wire logic       clk_sys,
    output logic      [5:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move between clock edges
    always @(negedge clk_sys) begin
        pin_lvl <= level_tgt;
    end
endmodule

// >>> tb/tb_pced_top.sv
/* Register and edge tests for pced_top.
   Assumes the pin model and checker. */
module tb_pced_top
    import pced_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_o;
    logic [31:0] rdata;
    logic        ack_o;
    logic        irq_o;
    pced_pins_t  pin_tgt = 6'h0;
    pced_pins_t  pins;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #4 clk_sys = ~clk_sys;
    pced_pin_model pin_u (.level_tgt(pin_tgt), .clk_sys(clk_sys), .pin_lvl(pins));
    pced_top #(.NPINS(6)) dut_u (.clk_sys(clk_sys), .reset(reset), .pin_in(pins),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {26'h0, a, 2'h0};
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_sys); while (ack_o !== 1'b1);
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdata, exp);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd(i[3:0], 32'h0);
        bus(1'b1, 4'h0, 32'hFF, 4'hF);
        bus(1'b1, 4'h1, 32'hFF, 4'hF);
        rd(4'h0, 32'h3F);
        rd(4'h1, 32'h3F);
        bus(1'b1, 4'h0, 32'h15, 4'hF);
        bus(1'b1, 4'h1, 32'h2A, 4'hF);
        bus(1'b1, 4'h3, 32'h1, 4'hF);
        $display("test registers done");
        pin_tgt <= 6'h3F;
        repeat (6) @(posedge clk_sys);
        rd(4'h2, 32'h15);
        rd(4'h3, 32'h3);
        irq_is(1'b1);
        bus(1'b1, 4'h2, 32'h0, 4'hF);
        rd(4'h2, 32'h0);
        irq_is(1'b0);
        pin_tgt <= 6'h0;
        repeat (6) @(posedge clk_sys);
        rd(4'h2, 32'h2A);
        bus(1'b1, 4'h2, 32'h1, 4'hF);
        rd(4'h2, 32'h1);
        bus(1'b1, 4'h2, 32'h0, 4'hF);
        bus(1'b1, 4'h3, 32'h0, 4'hF);
        $display("test edges done");
        rd(4'h4, 32'h3);
        irq_is(1'b0);
        bus(1'b1, 4'h5, 32'h3, 4'hF);
        irq_is(1'b1);
        bus(1'b1, 4'h4, 32'h3, 4'hF);
        rd(4'h4, 32'h0);
        irq_is(1'b0);
        rd(4'hF, 32'h0);
        bus(1'b1, 4'h0, 32'h0, 4'hE);
        rd(4'h0, 32'h15);
        $display("test interrupts done");
        end_of_test();
    end
endmodule
